// [dv/tb_timer_channel_capture_compare_cfg.sv]
// Self-checking bench for the channel block over Avalon-MM with a pin model.
// Assumes one 100 MHz clock and the register map of the design package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_timer_channel_capture_compare_cfg;
   import tccc_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_waitrequest, count_down = 1'b0, update_event = 1'b0, ext_trigger_filtered = 1'b0;
   logic internal_trigger_input = 1'b0, pm_start = 1'b0, pm_busy;
   logic [15:0] counter_value = 16'h0;
   logic [2:0] trigger_source_sel = 3'h0;
   logic [1:0] protect_level = 2'h0;
   logic [3:0] ch_in, ch_out_reference, ch_out_pin, capture_event, pm_mask = 4'h0;
   logic [7:0] pm_n = 8'h00;
   logic [8:0] pm_half = 9'h1;
   int n_errors = 0, n_tests = 0, cycles = 0;
   int n_cap [4] = '{0, 0, 0, 0};

   tccc_channels dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .counter_value(counter_value),
      .count_down(count_down), .update_event(update_event), .ext_trigger_filtered(ext_trigger_filtered),
      .internal_trigger_input(internal_trigger_input), .trigger_source_sel(trigger_source_sel),
      .protect_level(protect_level), .ch_in(ch_in), .ch_out_reference(ch_out_reference),
      .ch_out_pin(ch_out_pin), .capture_event(capture_event));
   tccc_pin_model pins_far (.mclk(mclk), .start(pm_start), .mask(pm_mask), .n_toggle(pm_n),
      .half(pm_half), .busy(pm_busy), .ch_in(ch_in));

   always #5 mclk = ~mclk;

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      for (int k = 0; k < 4; k++) begin
         if (capture_event[k] === 1'b1) begin
            n_cap[k]++;
         end
      end
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_write

   task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge mclk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      `CHK(nm, e, avs_readdata)
      avs_read <= 1'b0;
   endtask : rd_chk

   task oc2(input logic [2:0] code, input logic shd, input logic clr);
      bus_write(TCCC_ADDR_CTL1, {24'h0, clr, code, shd, 3'h0});
   endtask : oc2

   task ref_chk(input int k, input logic e);
      cyc(5);
      `CHK("out_reference", e, ch_out_reference[k])
   endtask : ref_chk

   task pins(input logic [3:0] m, input logic [7:0] n, input logic [8:0] h);
      pm_mask <= m;
      pm_n <= n;
      pm_half <= h;
      pm_start <= 1'b1;
      @(posedge mclk);
      pm_start <= 1'b0;
      do @(posedge mclk); while (pm_busy !== 1'b0);
      cyc(12);
   endtask : pins

   task its_train();
      repeat (4) begin
         internal_trigger_input <= 1'b1;
         cyc(6);
         internal_trigger_input <= 1'b0;
         cyc(6);
      end
   endtask : its_train

   task t_reset_lock();
      rd_chk(TCCC_ADDR_PE, 32'h0, "pe_reset");
      rd_chk(TCCC_ADDR_CTL1, 32'h0, "ctl1_reset");
      rd_chk(8'h24, 32'h0, "unmapped");
      bus_write(TCCC_ADDR_CTL1, 32'h201);
      bus_write(TCCC_ADDR_PE, 32'h1100);
      bus_write(TCCC_ADDR_CTL1, 32'h0);
      rd_chk(TCCC_ADDR_CTL1, 32'h201, "mode_locked");
      bus_write(TCCC_ADDR_PE, 32'h0);
      bus_write(TCCC_ADDR_CTL1, 32'h0);
      rd_chk(TCCC_ADDR_CTL1, 32'h0, "mode_free");
      $display("test reset_lock done");
   endtask : t_reset_lock

   task t_protect();
      protect_level <= 2'h2;
      bus_write(TCCC_ADDR_PE, 32'h303, 4'h3);
      rd_chk(TCCC_ADDR_PE, 32'h101, "pol_blocked");
      protect_level <= 2'h0;
      bus_write(TCCC_ADDR_PE, 32'h0, 4'h1);
      bus_write(TCCC_ADDR_PE, 32'h0, 4'hC);
      rd_chk(TCCC_ADDR_PE, 32'h101, "pe_lanes");
      bus_write(TCCC_ADDR_PE, 32'h0);
      rd_chk(TCCC_ADDR_PE, 32'h0, "pe_word");
      $display("test protect done");
   endtask : t_protect

   task t_compare();
      counter_value <= 16'h0;
      bus_write(TCCC_ADDR_CV2, 32'h10);
      oc2(TCCC_OC_HIGH, 1'b0, 1'b0);
      ref_chk(2, 1'b1);
      oc2(TCCC_OC_TIMING, 1'b0, 1'b0);
      counter_value <= 16'h0010;
      ref_chk(2, 1'b1);
      oc2(TCCC_OC_CLR, 1'b0, 1'b0);
      ref_chk(2, 1'b0);
      oc2(TCCC_OC_SET, 1'b0, 1'b0);
      ref_chk(2, 1'b1);
      oc2(TCCC_OC_LOW, 1'b0, 1'b0);
      counter_value <= 16'h0000;
      ref_chk(2, 1'b0);
      oc2(TCCC_OC_TOG, 1'b0, 1'b0);
      counter_value <= 16'h0010;
      cyc(1);
      counter_value <= 16'h0000;
      ref_chk(2, 1'b1);
      bus_write(TCCC_ADDR_PE, 32'h100);
      cyc(4);
      `CHK("out_pin", 1'b1, ch_out_pin[2])
      bus_write(TCCC_ADDR_PE, 32'h300);
      cyc(4);
      `CHK("out_pin", 1'b0, ch_out_pin[2])
      bus_write(TCCC_ADDR_PE, 32'h0);
      $display("test compare done");
   endtask : t_compare

   task t_pwm();
      bus_write(TCCC_ADDR_CV2, 32'h20);
      oc2(TCCC_OC_PWM0, 1'b1, 1'b0);
      update_event <= 1'b1;
      cyc(1);
      update_event <= 1'b0;
      counter_value <= 16'h0010;
      ref_chk(2, 1'b1);
      counter_value <= 16'h0030;
      ref_chk(2, 1'b0);
      count_down <= 1'b1;
      counter_value <= 16'h0020;
      ref_chk(2, 1'b1);
      oc2(TCCC_OC_TIMING, 1'b1, 1'b0);
      oc2(TCCC_OC_PWM1, 1'b1, 1'b0);
      ref_chk(2, 1'b0);
      counter_value <= 16'h0030;
      ref_chk(2, 1'b1);
      count_down <= 1'b0;
      counter_value <= 16'h0010;
      ref_chk(2, 1'b0);
      bus_write(TCCC_ADDR_CV2, 32'h8);
      ref_chk(2, 1'b0);
      update_event <= 1'b1;
      cyc(1);
      update_event <= 1'b0;
      ref_chk(2, 1'b1);
      oc2(TCCC_OC_HIGH, 1'b0, 1'b1);
      ext_trigger_filtered <= 1'b1;
      ref_chk(2, 1'b0);
      ext_trigger_filtered <= 1'b0;
      $display("test pwm done");
   endtask : t_pwm

   task automatic t_capture();
      // rows cover filter codes 0011 and 1111 and both edges.
      logic [7:0] ctl [8] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h31, 8'h31, 8'hF1, 8'h01};
      logic [3:0] pe [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'hB};
      logic [7:0] tog [8] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h02, 8'h04, 8'h02, 8'h10};
      logic [8:0] hp [8] = '{9'h6, 9'h6, 9'h6, 9'h6, 9'h3, 9'h10, 9'h190, 9'h6};
      int ex [8] = '{8, 4, 2, 1, 0, 2, 1, 16};
      counter_value <= 16'h1234;
      for (int i = 0; i < 8; i++) begin
         bus_write(TCCC_ADDR_PE, 32'h0);
         bus_write(TCCC_ADDR_CTL0, {24'h0, ctl[i]});
         bus_write(TCCC_ADDR_PE, {28'h0, pe[i]});
         n_cap[0] = 0;
         pins(4'h1, tog[i], hp[i]);
         `CHK("captures", ex[i], n_cap[0])
      end
      rd_chk(TCCC_ADDR_CV0, 32'h1234, "capture_value");
      bus_write(TCCC_ADDR_PE, 32'h0);
      bus_write(TCCC_ADDR_CTL0, 32'h5);
      bus_write(TCCC_ADDR_PE, 32'h1);
      n_cap[0] = 0;
      pins(4'h1, 8'h02, 9'h6);
      bus_write(TCCC_ADDR_PE, 32'h0);
      bus_write(TCCC_ADDR_PE, 32'h1);
      pins(4'h1, 8'h02, 9'h6);
      `CHK("prescaler_reset", 0, n_cap[0])
      $display("test capture done");
   endtask : t_capture

   task t_route();
      bus_write(TCCC_ADDR_PE, 32'h0);
      bus_write(TCCC_ADDR_CTL1, 32'h300);
      bus_write(TCCC_ADDR_PE, 32'h1000);
      trigger_source_sel <= 3'h4;
      n_cap[3] = 0;
      its_train();
      `CHK("trigger_off", 0, n_cap[3])
      trigger_source_sel <= TCCC_TRG_INT_MAX;
      its_train();
      cyc(8);
      `CHK("trigger_on", 4, n_cap[3])
      bus_write(TCCC_ADDR_PE, 32'h0);
      bus_write(TCCC_ADDR_CTL1, 32'h200);
      bus_write(TCCC_ADDR_PE, 32'h1000);
      n_cap[3] = 0;
      pins(4'h4, 8'h08, 9'h6);
      `CHK("neighbour", 4, n_cap[3])
      $display("test route done");
   endtask : t_route

   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset_lock();
      t_protect();
      t_compare();
      t_pwm();
      t_capture();
      t_route();
      print_verdict();
   end
endmodule : tb_timer_channel_capture_compare_cfg
`default_nettype wire

// [dv/tccc_channels_asserts.sv]
// Checker for the bus handshake, readout and reset of the channel block.
// Bound to tccc_channels; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tccc_channels_chk
   import tccc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [3:0] ch_out_reference,
   input wire logic [3:0] ch_out_pin,
   input wire logic [3:0] capture_event
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   wire logic req = avs_read | avs_write;
   wire logic rd_done = avs_read & ~avs_waitrequest;
   wire logic is_ctl = (avs_address == TCCC_ADDR_CTL0) || (avs_address == TCCC_ADDR_CTL1);
   wire logic is_cv = (avs_address == TCCC_ADDR_CV0) || (avs_address == TCCC_ADDR_CV1) ||
      (avs_address == TCCC_ADDR_CV2) || (avs_address == TCCC_ADDR_CV3);
   wire logic mapped = is_ctl || is_cv || (avs_address == TCCC_ADDR_PE);

   a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
      else $error("waitrequest low in first request cycle");
   a_wait_one: assert property (req && avs_waitrequest |=> !req || !avs_waitrequest)
      else $error("more than one wait cycle");
   a_wait_idle: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest high without request");
   // Reset itself is the antecedent here, so this one cannot be disabled by it.
   a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> ch_out_reference == 4'h0 && ch_out_pin == 4'h0 && capture_event == 4'h0)
      else $error("outputs not cleared by reset");
   a_unmapped_zero: assert property (rd_done && !mapped |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_pe_reserved: assert property (rd_done && avs_address == TCCC_ADDR_PE |->
      (avs_readdata & 32'hFFFF_4444) == 32'h0)
      else $error("reserved polarity bits read nonzero");
   a_ctl_upper: assert property (rd_done && is_ctl |-> avs_readdata[31:16] == 16'h0)
      else $error("control upper half nonzero");
   a_cv_upper: assert property (rd_done && is_cv |-> avs_readdata[31:16] == 16'h0)
      else $error("compare value upper half nonzero");
   a_rdata_hold: assert property ($changed(avs_readdata) |-> rd_done)
      else $error("read data changed outside a read");

   cover property (capture_event[0]);
   cover property (ch_out_pin[2]);
   cover property (avs_write && !avs_waitrequest && avs_address == TCCC_ADDR_PE);
endmodule : tccc_channels_chk

bind tccc_channels tccc_channels_chk u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ch_out_reference(ch_out_reference),
   .ch_out_pin(ch_out_pin), .capture_event(capture_event));
`default_nettype wire

// [dv/tccc_pin_model.sv]
// Behavioural model of the timer channel input pins.
// Toggles the masked pins a set number of times, a set number of cycles apart.
`timescale 1ns/1ps
`default_nettype none
module tccc_pin_model (
   input wire logic mclk,
   input wire logic start,
   input wire logic [3:0] mask,
   input wire logic [7:0] n_toggle,
   input wire logic [8:0] half,
   output logic busy,
   output logic [3:0] ch_in
);
   logic [7:0] left;
   logic [8:0] tick;
   initial begin
      busy = 1'b0;
      ch_in = 4'h0;
      left = 8'h00;
      tick = 9'h000;
   end
   // Busy stays up one spacing past the last toggle so the filter can settle.
   always @(posedge mclk) begin
      if (start) begin
         left <= n_toggle;
         tick <= half;
         busy <= 1'b1;
      end else if (busy) begin
         if (tick > 9'h001) begin
            tick <= tick - 9'h001;
         end else if (left != 8'h00) begin
            ch_in <= ch_in ^ mask;
            left <= left - 8'h01;
            tick <= half;
         end else begin
            busy <= 1'b0;
         end
      end
   end
endmodule : tccc_pin_model
`default_nettype wire

// [rtl/tccc_channels.sv]
// Capture/compare configuration and channel logic for four timer channels.
// Assumes the counter, update event, trigger and protection sources live
// outside and share mclk; channel pins and the external trigger are async.
// Functional notes
// - Channel 2 mode: 00 output, 01 own, 10 channel 3, 11 internal trigger.
// - Mode field writes only accepted while the channel enable is clear.
// - Internal trigger input works only when an internal trigger source is chosen.
// - Channel 3 mode: 01 own input, 10 channel 2 input.
// - Clear enable with external trigger high clears the output reference.
// - Timing mode holds the output reference unchanged.
// - On match: 001 sets, 010 clears, 011 toggles the reference.
// - Code 100 forces reference low, 101 forces it high.
// - PWM 0: active below compare counting up, inactive above counting down.
// - PWM 1: inverse of PWM 0 in both counting directions.
// - PWM level changes only leaving timing mode or on compare result change.
// - Shadow enable uses a compare copy loaded at each update event.
// - Filter codes pick sample clock divider and sample count per table.
// - Capture prescaler captures every 1, 2, 4 or 8 edges.
// - Clearing the channel enable resets its prescaler edge count.
// - Polarity/enable register takes half-word and word accesses.
// - Output mode polarity 0 is active high, 1 active low.
// - Input polarity pair: 00 rising, 01 falling inverted, 11 both edges.
// - Polarity bits ignore writes while protection level is 10 or 11.
// - Enable activates output pin or capture events; clear disables channel.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tccc_channels
   import tccc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [15:0] counter_value,
   input wire logic count_down,
   input wire logic update_event,
   input wire logic ext_trigger_filtered,
   input wire logic internal_trigger_input,
   input wire logic [2:0] trigger_source_sel,
   input wire logic [1:0] protect_level,
   input wire logic [3:0] ch_in,
   output logic [3:0] ch_out_reference,
   output logic [3:0] ch_out_pin,
   output logic [3:0] capture_event
);

   // Sample count needed before a new input level is accepted.
   function automatic logic [3:0] flt_times(input logic [3:0] code);
      case (code)
         4'h1: flt_times = 4'h2;
         4'h2: flt_times = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: flt_times = 4'h6;
         4'hA, 4'hD: flt_times = 4'h5;
         default: flt_times = 4'h8;
      endcase
   endfunction : flt_times

   // Log2 of the dead-time clock division used for sampling.
   function automatic logic [2:0] flt_shift(input logic [3:0] code);
      case (code)
         4'h4, 4'h5: flt_shift = 3'h1;
         4'h6, 4'h7: flt_shift = 3'h2;
         4'h8, 4'h9: flt_shift = 3'h3;
         4'hA, 4'hB, 4'hC: flt_shift = 3'h4;
         4'hD, 4'hE, 4'hF: flt_shift = 3'h5;
         default: flt_shift = 3'h0;
      endcase
   endfunction : flt_shift

   // Address decode of the four compare value registers.
   function automatic logic cv_hit(input logic [7:0] addr, input int k);
      cv_hit = (addr == TCCC_ADDR_CV0 + 8'(4 * k));
   endfunction : cv_hit

   logic ack;
   logic wr_go;
   logic be_full;
   logic be_half_lo;
   logic be_half_hi;
   logic [31:0] next_readdata;
   logic [7:0] ctl_byte [TCCC_NCH];
   logic [3:0] pe_nib [TCCC_NCH];
   logic [15:0] cv [TCCC_NCH];
   logic [15:0] cmp_act [TCCC_NCH];
   logic [3:0] in_s1;
   logic [3:0] in_s2;
   logic etr_s1;
   logic etr_s2;
   logic [TCCC_DIV_W-1:0] div_cnt;
   logic [3:0] flt_cnt [TCCC_NCH];
   logic [3:0] flt_lvl;
   logic [3:0] sel_q;
   logic [2:0] psc_cnt [TCCC_NCH];
   logic [3:0] pwm_q;
   logic [2:0] mode_q [TCCC_NCH];
   logic its_ok;
   logic [3:0] sel_lvl;
   logic [3:0] cap_edge;
   logic [3:0] pwm_lvl;
   logic [3:0] match;
   logic [15:0] cmp_eff [TCCC_NCH];

   // The bus answers every request after exactly one wait cycle.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_go = avs_write & ack;
   assign be_full = (avs_byteenable == 4'hF);
   assign be_half_lo = (avs_byteenable == 4'h3);
   assign be_half_hi = (avs_byteenable == 4'hC);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_address == TCCC_ADDR_CTL0) begin
         next_readdata = {16'h0, ctl_byte[1], ctl_byte[0]};
      end else if (avs_address == TCCC_ADDR_CTL1) begin
         next_readdata = {16'h0, ctl_byte[3], ctl_byte[2]};
      end else if (avs_address == TCCC_ADDR_PE) begin
         next_readdata = {16'h0, pe_nib[3], pe_nib[2], pe_nib[1], pe_nib[0]};
      end
      for (int k = 0; k < TCCC_NCH; k++) begin
         if (cv_hit(avs_address, k)) begin
            next_readdata = {16'h0, cv[k]};
         end
      end
   end

   // Read data is captured in the wait cycle so it stands when waitrequest drops.
   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_readdata;
      end
   end

   // Control bytes; the channel control registers take word access only.
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            ctl_byte[k] <= TCCC_CTL_RST;
         end
      end else if (wr_go && be_full) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            if ((k < 2 && avs_address == TCCC_ADDR_CTL0) || (k >= 2 && avs_address == TCCC_ADDR_CTL1)) begin
               ctl_byte[k][7:2] <= avs_writedata[8 * (k % 2) + 2 +: 6];
               if (!pe_nib[k][TCCC_P_EN]) begin
                  ctl_byte[k][TCCC_F_MS +: 2] <= avs_writedata[8 * (k % 2) +: 2];
               end
            end
         end
      end
   end

   // Polarity and enable nibbles.
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            pe_nib[k] <= TCCC_PE_RST;
         end
      end else if (wr_go && avs_address == TCCC_ADDR_PE && (be_full || be_half_lo || be_half_hi)) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            if (avs_byteenable[k / 2]) begin
               pe_nib[k][TCCC_P_EN] <= avs_writedata[4 * k + TCCC_P_EN];
               if (!protect_level[1]) begin
                  pe_nib[k][TCCC_P_P] <= avs_writedata[4 * k + TCCC_P_P];
                  pe_nib[k][TCCC_P_NP] <= avs_writedata[4 * k + TCCC_P_NP];
               end
            end
         end
      end
   end

   // Pin and external trigger synchronisers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         in_s1 <= 4'h0;
         in_s2 <= 4'h0;
         etr_s1 <= 1'b0;
         etr_s2 <= 1'b0;
      end else begin
         in_s1 <= ch_in;
         in_s2 <= in_s1;
         etr_s1 <= ext_trigger_filtered;
         etr_s2 <= etr_s1;
      end
   end

   // The dead-time clock equals the timer clock here; divisions come from one counter.
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Digital input filters.
   always_ff @(posedge mclk) begin
      if (rst) begin
         flt_lvl <= 4'h0;
         for (int k = 0; k < TCCC_NCH; k++) begin
            flt_cnt[k] <= 4'h0;
         end
      end else begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            logic [3:0] code;
            logic [TCCC_DIV_W-1:0] mask;
            code = ctl_byte[k][TCCC_F_FLT +: 4];
            mask = TCCC_DIV_W'((1 << flt_shift(code)) - 1);
            if (code == 4'h0) begin
               flt_lvl[k] <= in_s2[k];
               flt_cnt[k] <= 4'h0;
            end else if ((div_cnt & mask) == '0) begin
               if (in_s2[k] == flt_lvl[k]) begin
                  flt_cnt[k] <= 4'h0;
               end else if (flt_cnt[k] + 4'h1 >= flt_times(code)) begin
                  flt_lvl[k] <= in_s2[k];
                  flt_cnt[k] <= 4'h0;
               end else begin
                  flt_cnt[k] <= flt_cnt[k] + 4'h1;
               end
            end
         end
      end
   end

   assign its_ok = (trigger_source_sel <= TCCC_TRG_INT_MAX);

   always_comb begin
      for (int k = 0; k < TCCC_NCH; k++) begin
         logic [1:0] pol;
         logic raw;
         raw = 1'b0;
         pol = {pe_nib[k][TCCC_P_NP], pe_nib[k][TCCC_P_P]};
         case (ctl_byte[k][TCCC_F_MS +: 2])
            TCCC_MS_OWN: raw = flt_lvl[k];
            // neighbour pairing, pairs 0-1 and 2-3
            TCCC_MS_NBR: raw = flt_lvl[k ^ 1];
            TCCC_MS_ITS: raw = its_ok & internal_trigger_input;
            default: raw = 1'b0;
         endcase
         sel_lvl[k] = (pol == TCCC_POL_FALL) ? ~raw : raw;
         cap_edge[k] = (pol == TCCC_POL_BOTH) ? (sel_lvl[k] ^ sel_q[k]) : (sel_lvl[k] & ~sel_q[k]);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sel_q <= 4'h0;
      end else begin
         sel_q <= sel_lvl;
      end
   end

   // Capture prescaler, capture pulses and compare value registers.
   always_ff @(posedge mclk) begin
      if (rst) begin
         capture_event <= 4'h0;
         for (int k = 0; k < TCCC_NCH; k++) begin
            psc_cnt[k] <= 3'h0;
            cv[k] <= TCCC_CV_RST;
         end
      end else begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            logic [2:0] limit;
            logic in_mode;
            limit = 3'((1 << ctl_byte[k][TCCC_F_PSC +: 2]) - 1);
            in_mode = (ctl_byte[k][TCCC_F_MS +: 2] != TCCC_MS_OUT);
            capture_event[k] <= 1'b0;
            if (!pe_nib[k][TCCC_P_EN]) begin
               psc_cnt[k] <= 3'h0;
            // capture only when enabled, edge division
            end else if (in_mode && cap_edge[k]) begin
               if (psc_cnt[k] >= limit) begin
                  psc_cnt[k] <= 3'h0;
                  capture_event[k] <= 1'b1;
                  cv[k] <= counter_value;
               end else begin
                  psc_cnt[k] <= psc_cnt[k] + 3'h1;
               end
            end
            // Compare values are read-only while the channel is an input.
            if (wr_go && be_full && !in_mode && cv_hit(avs_address, k)) begin
               cv[k] <= avs_writedata[15:0];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            cmp_act[k] <= TCCC_CV_RST;
         end
      end else if (update_event) begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            cmp_act[k] <= cv[k];
         end
      end
   end

   always_comb begin
      for (int k = 0; k < TCCC_NCH; k++) begin
         cmp_eff[k] = ctl_byte[k][TCCC_F_SEN] ? cmp_act[k] : cv[k];
         match[k] = (counter_value == cmp_eff[k]);
         pwm_lvl[k] = count_down ? !(counter_value > cmp_eff[k]) : (counter_value < cmp_eff[k]);
         pwm_lvl[k] = pwm_lvl[k] ^ (ctl_byte[k][TCCC_F_CTL +: 3] == TCCC_OC_PWM1);
      end
   end

   // Output reference generation.
   always_ff @(posedge mclk) begin
      if (rst) begin
         ch_out_reference <= 4'h0;
         pwm_q <= 4'h0;
         for (int k = 0; k < TCCC_NCH; k++) begin
            mode_q[k] <= TCCC_OC_TIMING;
         end
      end else begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            logic [2:0] oc;
            oc = ctl_byte[k][TCCC_F_CTL +: 3];
            mode_q[k] <= oc;
            pwm_q[k] <= pwm_lvl[k];
            if (ctl_byte[k][TCCC_F_CEN] && etr_s2) begin
               ch_out_reference[k] <= 1'b0;
            end else begin
               case (oc)
                  TCCC_OC_SET: ch_out_reference[k] <= ch_out_reference[k] | match[k];
                  TCCC_OC_CLR: ch_out_reference[k] <= ch_out_reference[k] & ~match[k];
                  TCCC_OC_TOG: ch_out_reference[k] <= ch_out_reference[k] ^ match[k];
                  TCCC_OC_LOW: ch_out_reference[k] <= 1'b0;
                  TCCC_OC_HIGH: ch_out_reference[k] <= 1'b1;
                  TCCC_OC_PWM0, TCCC_OC_PWM1: ch_out_reference[k] <=
                     (mode_q[k] == TCCC_OC_TIMING || pwm_lvl[k] != pwm_q[k]) ? pwm_lvl[k] : ch_out_reference[k];
                  default: ch_out_reference[k] <= ch_out_reference[k];
               endcase
            end
         end
      end
   end

   // Pins idle low when disabled or in input mode.
   always_ff @(posedge mclk) begin
      if (rst) begin
         ch_out_pin <= 4'h0;
      end else begin
         for (int k = 0; k < TCCC_NCH; k++) begin
            ch_out_pin[k] <= (pe_nib[k][TCCC_P_EN] && ctl_byte[k][TCCC_F_MS +: 2] == TCCC_MS_OUT) ?
               ch_out_reference[k] ^ pe_nib[k][TCCC_P_P] : 1'b0;
         end
      end
   end

endmodule : tccc_channels

`default_nettype wire

// [rtl/tccc_pkg.sv]
// Package for the timer channel capture/compare configuration block.
// Holds register offsets, field positions, mode codes and filter timing.
// Assumes a 100 MHz timer clock and byte addresses on the register bus.
package tccc_pkg;

   localparam int TCCC_NCH = 4;
   localparam int TCCC_CNT_W = 16;

   // Register byte offsets.
   localparam logic [7:0] TCCC_ADDR_CTL0 = 8'h18;
   localparam logic [7:0] TCCC_ADDR_CTL1 = 8'h1C;
   localparam logic [7:0] TCCC_ADDR_PE = 8'h20;
   localparam logic [7:0] TCCC_ADDR_CV0 = 8'h34;
   localparam logic [7:0] TCCC_ADDR_CV1 = 8'h38;
   localparam logic [7:0] TCCC_ADDR_CV2 = 8'h3C;
   localparam logic [7:0] TCCC_ADDR_CV3 = 8'h40;

   // Reset values.
   localparam logic [7:0] TCCC_CTL_RST = 8'h00;
   localparam logic [3:0] TCCC_PE_RST = 4'h0;
   localparam logic [15:0] TCCC_CV_RST = 16'h0000;

   // Per-channel control byte fields.
   localparam int TCCC_F_MS = 0;
   localparam int TCCC_F_PSC = 2;
   localparam int TCCC_F_SEN = 3;
   localparam int TCCC_F_CTL = 4;
   localparam int TCCC_F_FLT = 4;
   localparam int TCCC_F_CEN = 7;

   // Per-channel polarity/enable nibble fields; bit 2 is reserved.
   localparam int TCCC_P_EN = 0;
   localparam int TCCC_P_P = 1;
   localparam int TCCC_P_NP = 3;
   localparam logic [3:0] TCCC_PE_MASK = 4'hB;

   // Mode selection codes.
   localparam logic [1:0] TCCC_MS_OUT = 2'h0;
   localparam logic [1:0] TCCC_MS_OWN = 2'h1;
   localparam logic [1:0] TCCC_MS_NBR = 2'h2;
   localparam logic [1:0] TCCC_MS_ITS = 2'h3;

   // Compare output control codes.
   localparam logic [2:0] TCCC_OC_TIMING = 3'h0;
   localparam logic [2:0] TCCC_OC_SET = 3'h1;
   localparam logic [2:0] TCCC_OC_CLR = 3'h2;
   localparam logic [2:0] TCCC_OC_TOG = 3'h3;
   localparam logic [2:0] TCCC_OC_LOW = 3'h4;
   localparam logic [2:0] TCCC_OC_HIGH = 3'h5;
   localparam logic [2:0] TCCC_OC_PWM0 = 3'h6;
   localparam logic [2:0] TCCC_OC_PWM1 = 3'h7;

   // Input edge polarity codes, {comp_polarity, polarity}.
   localparam logic [1:0] TCCC_POL_FALL = 2'h1;
   localparam logic [1:0] TCCC_POL_BOTH = 2'h3;

   // Trigger source codes up to this value are internal triggers.
   localparam logic [2:0] TCCC_TRG_INT_MAX = 3'h3;

   // Dead-time clock divider, kept as log2 of the division.
   localparam int TCCC_DIV_W = 5;

endpackage : tccc_pkg
